// File: pclk_gate_defs.svh
// Constants for the lower peripheral clock gate register.
// Assumes inclusion by bare name from the package and modules.
`ifndef PCLK_GATE_DEFS_SVH
`define PCLK_GATE_DEFS_SVH
`define GATE0_OFFSET   12'h024
`define GATE_LOW_MSB   17
`define GATE_NUM       10
// Writable gate bit mask over bits 17:0.
`define GATE_RW_MASK   18'h3a663
// Reserved bits read as ones; the whole low half resets to ones.
`define GATE_RESET     18'h3ffff
`define UPPER_RESET    14'h3fff
`define BIT_TIMER2_CLOCK_OFF       17
`define BIT_TIMER1_CLOCK_OFF       16
`define BIT_TIMER0_CLOCK_OFF       15
`define BIT_TWI0       13
`define BIT_ASY1       10
`define BIT_ASY0       9
`define BIT_SSP1       6
`define BIT_DMA        5
`define BIT_PIN1       1
`define BIT_PIN0       0
`endif

// File: pclk_gate_pkg.sv
// Types shared by the clock gate design files.
// Assumes pclk_gate_defs.svh is on the include path.
`include "pclk_gate_defs.svh"
package pclk_gate_pkg;
  typedef logic [`GATE_LOW_MSB:0] gate_word_t;
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACCESS = 1'b1
  } apb_state_t;
endpackage : pclk_gate_pkg

// File: gate_if.sv
// Carrier between the register and the per-peripheral gate stage.
// Assumes one clock domain.
`timescale 1ns/1ps
interface gate_if #(parameter int N = 10);
  logic [N-1:0] clock_off;
  logic [N-1:0] clock_en;
  logic [N-1:0] access_ok;
  modport ctrl (output clock_off, input clock_en, input access_ok);
  modport gate (input clock_off, output clock_en, output access_ok);
endinterface : gate_if

// File: gate_stage.sv
// Per-peripheral enable stage driven by gate bits.
// Assumes gate bits are registered in the same clock domain.
`timescale 1ns/1ps
module gate_stage #(
  parameter int N = 10
) (
  gate_if.gate g
);
  // ===========================================================
  // Enable generation
  // ===========================================================
  // Each peripheral gets a clock enable and a bus access permit.
  for (genvar i = 0; i < N; i++) begin : g_gate
    assign g.clock_en[i]  = ~g.clock_off[i];
    assign g.access_ok[i] = ~g.clock_off[i];
  end
endmodule : gate_stage

// File: peripheral_clock_gate_low.sv
// Lower half of the peripheral clock gate register, APB slave.
// Assumes the upper half and other registers share the word and
// that peripherals honour the enable and access-permit outputs.
//
// Behaviour
// - Bit 0 clocks peripheral; reset to one.
// - Set bit stops all peripheral activity.
// - Gated peripheral ignores bus accesses.
// - Gating keeps peripheral register contents.
// - Timer gates at bits 17, 16, 15.
// - Serial gates at bits 13, 10, 9, 6.
// - DMA bit 5, pin ports bits 1, 0.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "pclk_gate_defs.svh"
module peripheral_clock_gate_low
  import pclk_gate_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [9:0]  o_clock_en,
  output logic      [9:0]  o_access_ok
);
  gate_word_t      gate_q,  gate_d;
  logic [31:0]     rdata_q, rdata_d;
  apb_state_t      st_q,    st_d;
  logic            hit;
  logic            acc;
  logic [31:0]     wmask;
  gate_word_t      wbits;
  logic [31:0]     word;

  gate_if #(.N(`GATE_NUM)) gif ();

  gate_stage #(.N(`GATE_NUM)) u_stage (
    .g (gif)
  );

  // ===========================================================
  // Gate bit routing
  // ===========================================================
  // Coined field order: timers, serial ports, DMA, pin ports.
  // timer, serial port, DMA and pin port gate bits.
  assign gif.clock_off[9] = gate_q[`BIT_TIMER2_CLOCK_OFF];
  assign gif.clock_off[8] = gate_q[`BIT_TIMER1_CLOCK_OFF];
  assign gif.clock_off[7] = gate_q[`BIT_TIMER0_CLOCK_OFF];
  assign gif.clock_off[6] = gate_q[`BIT_TWI0];
  assign gif.clock_off[5] = gate_q[`BIT_ASY1];
  assign gif.clock_off[4] = gate_q[`BIT_ASY0];
  assign gif.clock_off[3] = gate_q[`BIT_SSP1];
  assign gif.clock_off[2] = gate_q[`BIT_DMA];
  assign gif.clock_off[1] = gate_q[`BIT_PIN1];
  assign gif.clock_off[0] = gate_q[`BIT_PIN0];
  assign o_clock_en  = gif.clock_en;
  assign o_access_ok = gif.access_ok;

  // ===========================================================
  // APB decode
  // ===========================================================
  // One-wait-free slave: answers in the access phase at once.
  assign hit       = (i_paddr == `GATE0_OFFSET);
  assign acc       = i_psel && i_penable && (st_q == ST_ACCESS);
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata  = rdata_q;
  assign word      = {`UPPER_RESET, gate_q};

  // Byte strobes mask the write data.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_pstrb[b]}};
    end
    wbits = i_pwdata[`GATE_LOW_MSB:0] & wmask[`GATE_LOW_MSB:0];
  end

  // Next register state and read data.
  always_comb begin
    gate_d  = gate_q;
    rdata_d = rdata_q;
    st_d    = st_q;
    case (st_q)
      ST_IDLE: begin
        if (i_psel && !i_penable) begin
          st_d = ST_ACCESS;
          // Read data is captured in setup so it is ready at access.
          rdata_d = (hit && !i_pwrite) ? word : 32'h0000_0000;
        end
      end
      ST_ACCESS: begin
        if (acc && i_pwrite && hit) begin
          gate_d = (gate_q & ~`GATE_RW_MASK)
                 | ((gate_q & ~{wmask[`GATE_LOW_MSB:0]})
                    & `GATE_RW_MASK)
                 | (wbits & `GATE_RW_MASK);
        end
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Register stage; gate bits start as all ones.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      gate_q  <= `GATE_RESET;
      rdata_q <= 32'h0000_0000;
      st_q    <= ST_IDLE;
    end else begin
      gate_q  <= gate_d;
      rdata_q <= rdata_d;
      st_q    <= st_d;
    end
  end
endmodule : peripheral_clock_gate_low

// File: periph_model.sv
// Model of the gated peripherals: one stored bit per lane.
// Assumes the permit lanes come from the gate register.
`timescale 1ns/1ps
module periph_model (
  input  wire logic       i_clock,
  input  wire logic [9:0] i_access_ok,
  input  wire logic       i_we,
  input  wire logic [9:0] i_wdata,
  output logic      [9:0] o_rdata
);
  logic [9:0] mem_q = 10'h0;
  always @(posedge i_clock)
    if (i_we) mem_q <= mem_q & ~i_access_ok | i_wdata & i_access_ok;
  assign o_rdata = mem_q & i_access_ok;
endmodule : periph_model

// File: pclk_gate_assertions.sv
// Checks of the lower gate register at its top ports.
// Assumes zero-wait APB and lanes timer2 down to pin0.
`timescale 1ns/1ps
module pclk_gate_assertions (
  input wire logic        i_clock, i_resetn, i_psel, i_penable,
  input wire logic        i_pwrite, o_pready, o_pslverr,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata, o_prdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [9:0]  o_clock_en, o_access_ok
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire a = i_psel & i_penable;
  wire h = i_paddr == 12'h024;
  function automatic logic [9:0] f(logic [31:0] w);
    return ~{w[17:15], w[13], w[10:9], w[6:5], w[1:0]};
  endfunction : f
  zero_wait_a: assert property (o_pready == a) else $error("ready");
  bad_addr_a: assert property (a |-> o_pslverr == !h) else $error("err");
  reset_off_a: assert property ($rose(i_resetn) |-> o_clock_en == 0)
    else $error("reset");
  write_map_a: assert property (a && i_pwrite && h && &i_pstrb |=>
    o_clock_en == f($past(i_pwdata))) else $error("write");
  read_map_a: assert property (a && !i_pwrite && h |->
    o_clock_en == f(o_prdata)) else $error("read");
  rsvd_one_a: assert property (a && !i_pwrite && h |->
    (o_prdata | 32'h3a663) == 32'hffffffff) else $error("rsvd");
  gate_hold_a: assert property (!(a && i_pwrite && h) |=>
    $stable(o_clock_en)) else $error("hold");
  permit_a: assert property (o_access_ok == o_clock_en) else $error("ok");
  cover property (a && i_pwrite && h);
  cover property (a && !i_pwrite && h);
  cover property (a && !h);
endmodule : pclk_gate_assertions
bind peripheral_clock_gate_low pclk_gate_assertions chk (.i_clock, .i_resetn,
  .i_psel, .i_penable, .i_pwrite, .o_pready, .o_pslverr, .i_paddr,
  .i_pwdata, .o_prdata, .i_pstrb, .o_clock_en, .o_access_ok);

// File: peripheral_clock_gate_low_bench.sv
// Random and corner writes to the gate register, checked by read.
// Assumes zero-wait APB slave at byte address 0x024.
`timescale 1ns/1ps
module peripheral_clock_gate_low_bench;
  logic c = 0, rn = 0, ps = 0, pe = 0, pw = 0, we = 0, re;
  logic [11:0] pa = 0;
  logic [31:0] wd = 0, rd, s = 32'd80079;
  logic [3:0]  st = 0;
  logic [17:0] m = '1, k;
  logic [9:0]  md = 0;
  wire  [31:0] prd;
  wire  [9:0]  en, ok, mr;
  wire         rdy, err;
  int mismatches = 0, tests_run = 0;
  always #2.5 c = ~c;
  peripheral_clock_gate_low uut (.i_clock(c), .i_resetn(rn), .i_psel(ps),
    .i_penable(pe), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(wd),
    .i_pstrb(st), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .o_clock_en(en), .o_access_ok(ok));
  periph_model pm (.i_clock(c), .i_access_ok(ok), .i_we(we),
    .i_wdata(md), .o_rdata(mr));
  // Xorshift step that draws the next repeatable random word.
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic logic [9:0] ex(logic [17:0] w);
    return ~{w[17:15], w[13], w[10:9], w[6:5], w[1:0]};
  endfunction : ex
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      mismatches++;
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] b);
    @(posedge c) {ps, pw, pa, wd, st} <= {1'b1, w, a, d, b};
    @(posedge c) pe <= 1;
    do @(posedge c); while (rdy !== 1'b1);
    rd = prd;
    re = err;
    {ps, pe} <= 2'b00;
    k = {{2{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 18'h3a663;
    if (w && a == 12'h024) m = m & ~k | d[17:0] & k;
  endtask : apb
  task automatic pulse(logic [9:0] v);
    @(posedge c) {we, md} <= {1'b1, v};
    @(posedge c) we <= 0;
  endtask : pulse
  task automatic conclude;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // Empty, full and random words, then refusals and retention.
  initial begin
    repeat (8) @(posedge c);
    rn <= 1;
    for (int i = 0; i < 26; i++) begin
      apb(0, 12'h024, 0, 0);
      chk("word", {14'h3fff, m}, rd);
      chk("enable", ex(m), en);
      s = xs(s);
      apb(1, 12'h024, i < 2 ? {32{i[0]}} : s, i < 2 ? 4'hf : s[7:4]);
    end
    apb(1, 12'h028, 0, 4'hf);
    chk("slverr", 1, re);
    apb(0, 12'h028, 0, 0);
    chk("unmapped", 0, rd);
    apb(1, 12'h024, 0, 4'hf);
    pulse(10'h2aa);
    apb(1, 12'h024, 32'hffffffff, 4'hf);
    pulse(10'h155);
    chk("gated", 0, mr);
    apb(1, 12'h024, 0, 4'hf);
    @(posedge c);
    chk("kept", 10'h2aa, mr);
    conclude();
  end
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule : peripheral_clock_gate_low_bench
